// file: hw/afec_regbank.sv
/*
 * Control and status register bank for a two-amplifier optical sensing
 * front end: switch and coupling mode, two gain-resistor selections, the
 * first amplifier's enable, output status and bandwidth, and its
 * calibration-mode bit. Drives the analog switch, selector and enable lines.
 * Assumes an Avalon-MM master with waitrequest on I_REF_CLK, and an
 * amplifier output status that is already synchronous to I_REF_CLK.
 */
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/100ps

module afec_regbank
   import afec_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic [ADDR_W-1:0] i_AVS_ADDRESS,
   input wire logic i_AVS_READ,
   input wire logic i_AVS_WRITE,
   input wire logic [DATA_W-1:0] i_AVS_WRITEDATA,
   input wire logic [DATA_W/8-1:0] i_AVS_BYTEENABLE,
   output logic [DATA_W-1:0] o_AVS_READDATA,
   output logic o_AVS_WAITREQUEST,
   input wire logic i_AMP_ZERO_OUTPUT,
   output logic o_SWITCH_ZERO_ON,
   output logic o_SWITCH_ONE_ON,
   output logic o_SWITCH_TWO_ON,
   output logic o_SWITCH_THREE_ON,
   output logic o_SWITCH_FOUR_ON,
   output logic o_COUPLING_EXTERNAL,
   output logic o_COUPLING_AC,
   output logic o_COUPLING_DC,
   output logic [RESISTOR_CODE_W-1:0] o_FIRST_RESISTOR_CODE,
   output logic [RESISTOR_CODE_W-1:0] o_SECOND_RESISTOR_CODE,
   output logic [THIRD_CODE_W-1:0] o_THIRD_RESISTOR_CODE,
   output logic [KOHM_W-1:0] o_FIRST_RESISTOR_KOHM,
   output logic [KOHM_W-1:0] o_SECOND_RESISTOR_KOHM,
   output logic [KOHM_W-1:0] o_THIRD_RESISTOR_KOHM,
   output logic o_AMP_ZERO_ENABLE,
   output logic o_AMP_ZERO_CALIBRATION_MODE,
   output logic [BANDWIDTH_W-1:0] o_AMP_ZERO_BANDWIDTH_SELECT,
   output logic [3:0] o_AMP_ZERO_BANDWIDTH_ONEHOT
);

   afec_bus_state_t bus_state_q;
   afec_bus_state_t bus_state_d;
   logic req;
   logic commit;
   logic lane0_wr;
   logic wr_switch;
   logic wr_first;
   logic wr_second;
   logic wr_ctrl;
   logic wr_cal;
   logic [REG_W-1:0] switch_mode_ctrl;
   logic [REG_W-1:0] first_gain_select;
   logic [REG_W-1:0] second_gain_select;
   logic [REG_W-1:0] amp_zero_ctrl;
   logic [REG_W-1:0] amp_zero_cal;
   logic [REG_W-1:0] ctrl_status_view;
   logic [REG_W-1:0] rd_byte;
   logic [DATA_W-1:0] readdata_q;
   logic status_q;
   logic coupling_ext_q;
   logic coupling_ac_q;
   logic coupling_dc_q;
   logic [3:0] bw_onehot_q;
   logic [KOHM_W-1:0] first_kohm_q;
   logic [KOHM_W-1:0] second_kohm_q;
   logic [KOHM_W-1:0] third_kohm_q;
   afec_coupling_t coupling;
   afec_bandwidth_t bandwidth;
   logic cal_mode;

   // bus handshake: every request sees one wait cycle, then one ack cycle
   // fixed two-cycle access: no back-to-back, but no pipeline state
   assign req = i_AVS_READ | i_AVS_WRITE;
   assign commit = (bus_state_q == BUS_ACK) & i_AVS_WRITE;
   assign lane0_wr = commit & i_AVS_BYTEENABLE[0];

   always_comb begin
      bus_state_d = bus_state_q;
      case (bus_state_q)
         BUS_IDLE: begin
            if (req) begin
               bus_state_d = BUS_ACK;
            end
         end
         BUS_ACK: begin
            bus_state_d = BUS_IDLE;
         end
         default: begin
            bus_state_d = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         bus_state_q <= BUS_IDLE;
      end else begin
         bus_state_q <= bus_state_d;
      end
   end

   // waitrequest is high whenever no ack is due, so it is a flop output
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         o_AVS_WAITREQUEST <= 1'b1;
      end else begin
         o_AVS_WAITREQUEST <= ~((bus_state_q == BUS_IDLE) & req);
      end
   end

   // write decode; an unmapped or misaligned address stores nothing
   // lane 0 only: the upper byte lanes hold no register bits
   always_comb begin
      wr_switch = 1'b0;
      wr_first = 1'b0;
      wr_second = 1'b0;
      wr_ctrl = 1'b0;
      wr_cal = 1'b0;
      if (!lane0_wr) begin
         wr_switch = 1'b0;
      end else if (i_AVS_ADDRESS == OFS_SWITCH_MODE) begin
         wr_switch = 1'b1;
      end else if (i_AVS_ADDRESS == OFS_FIRST_GAIN) begin
         wr_first = 1'b1;
      end else if (i_AVS_ADDRESS == OFS_SECOND_GAIN) begin
         wr_second = 1'b1;
      end else if (i_AVS_ADDRESS == OFS_AMP_ZERO_CTRL) begin
         wr_ctrl = 1'b1;
      end else if (i_AVS_ADDRESS == OFS_AMP_ZERO_CAL) begin
         wr_cal = 1'b1;
      end
   end

   // bit 7 absent; bits 6:0 are switches and coupling field
   afec_field_reg #(
      .WIDTH(REG_W),
      .MASK(MASK_SWITCH_MODE),
      .RST(RST_SWITCH_MODE)
   ) u_switch_mode_ctrl (
      .i_ref_clk(I_REF_CLK),
      .i_reset(I_RESET),
      .i_wr_en(wr_switch),
      .i_wr_data(i_AVS_WRITEDATA[REG_W-1:0]),
      .o_value(switch_mode_ctrl)
   );

   // six-bit code, bits 7:6 read zero
   afec_field_reg #(
      .WIDTH(REG_W),
      .MASK(MASK_FIRST_GAIN),
      .RST(RST_FIRST_GAIN)
   ) u_first_gain_select (
      .i_ref_clk(I_REF_CLK),
      .i_reset(I_RESET),
      .i_wr_en(wr_first),
      .i_wr_data(i_AVS_WRITEDATA[REG_W-1:0]),
      .o_value(first_gain_select)
   );

   // third code in 7:6, second code in 5:0
   afec_field_reg #(
      .WIDTH(REG_W),
      .MASK(MASK_SECOND_GAIN),
      .RST(RST_SECOND_GAIN)
   ) u_second_gain_select (
      .i_ref_clk(I_REF_CLK),
      .i_reset(I_RESET),
      .i_wr_en(wr_second),
      .i_wr_data(i_AVS_WRITEDATA[REG_W-1:0]),
      .o_value(second_gain_select)
   );

   // status bit 5 is not in the mask, so writes to it vanish
   afec_field_reg #(
      .WIDTH(REG_W),
      .MASK(MASK_AMP_ZERO_CTRL),
      .RST(RST_AMP_ZERO_CTRL)
   ) u_amp_zero_ctrl (
      .i_ref_clk(I_REF_CLK),
      .i_reset(I_RESET),
      .i_wr_en(wr_ctrl),
      .i_wr_data(i_AVS_WRITEDATA[REG_W-1:0]),
      .o_value(amp_zero_ctrl)
   );

   // only the calibration-mode bit is held here
   afec_field_reg #(
      .WIDTH(REG_W),
      .MASK(MASK_AMP_ZERO_CAL),
      .RST(RST_AMP_ZERO_CAL)
   ) u_amp_zero_cal (
      .i_ref_clk(I_REF_CLK),
      .i_reset(I_RESET),
      .i_wr_en(wr_cal),
      .i_wr_data(i_AVS_WRITEDATA[REG_W-1:0]),
      .o_value(amp_zero_cal)
   );

   // field views of the stored bytes
   assign cal_mode = amp_zero_cal[POS_CAL_MODE];
   assign coupling =
      afec_coupling_t'(switch_mode_ctrl[POS_COUPLING_LO +: $bits(afec_coupling_t)]);
   assign bandwidth = afec_bandwidth_t'(amp_zero_ctrl[POS_BANDWIDTH_LO +: BANDWIDTH_W]);

   // status follows the amplifier only in calibration, else held low
   // one-clock lag, harmless next to software polling
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         status_q <= 1'b0;
      end else if (cal_mode) begin
         status_q <= i_AMP_ZERO_OUTPUT;
      end else begin
         status_q <= 1'b0;
      end
   end

   // status overlays the unstored bit 5 on reads
   always_comb begin
      ctrl_status_view = amp_zero_ctrl;
      ctrl_status_view[POS_AMP_STATUS] = status_q;
   end

   // read mux; unmapped addresses answer zero rather than stalling
   always_comb begin
      rd_byte = '0;
      if (i_AVS_ADDRESS == OFS_SWITCH_MODE) begin
         rd_byte = switch_mode_ctrl;
      end else if (i_AVS_ADDRESS == OFS_FIRST_GAIN) begin
         rd_byte = first_gain_select;
      end else if (i_AVS_ADDRESS == OFS_SECOND_GAIN) begin
         rd_byte = second_gain_select;
      end else if (i_AVS_ADDRESS == OFS_AMP_ZERO_CTRL) begin
         rd_byte = ctrl_status_view;
      end else if (i_AVS_ADDRESS == OFS_AMP_ZERO_CAL) begin
         rd_byte = amp_zero_cal;
      end
   end

   // sampled in the wait cycle, shown through the ack cycle and after
   // held until the next read, so a late sampler still sees it
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         readdata_q <= '0;
      end else if ((bus_state_q == BUS_IDLE) & i_AVS_READ) begin
         readdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
      end
   end

   assign o_AVS_READDATA = readdata_q;

   // coupling decode; both external codes mean the same mode
   // registered so the switch drivers never see a decode glitch
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         coupling_ext_q <= 1'b1;
         coupling_ac_q <= 1'b0;
         coupling_dc_q <= 1'b0;
      end else begin
         coupling_ext_q <= (coupling == CPL_EXTERNAL_A) | (coupling == CPL_EXTERNAL_B);
         coupling_ac_q <= (coupling == CPL_AC);
         coupling_dc_q <= (coupling == CPL_DC);
      end
   end

   // bandwidth one-hot: bit0 5k, bit1 40k, bit2 600k, bit3 2M
   // one-hot so each bias leg gets its own enable line
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         bw_onehot_q <= 4'h1;
      end else begin
         case (bandwidth)
            BW_5KHZ: bw_onehot_q <= 4'h1;
            BW_40KHZ: bw_onehot_q <= 4'h2;
            BW_600KHZ: bw_onehot_q <= 4'h4;
            BW_2MHZ: bw_onehot_q <= 4'h8;
            default: bw_onehot_q <= 4'h1;
         endcase
      end
   end

   // nominal values for trim logic; code zero is a nonzero resistor in
   // silicon, so a zero kilohm figure means "minimum", not a short
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         first_kohm_q <= '0;
         second_kohm_q <= '0;
         third_kohm_q <= KOHM_W'(THIRD_KOHM_STEP);
      end else begin
         first_kohm_q <= KOHM_W'(KOHM_PER_COUNT)
            * KOHM_W'(first_gain_select[POS_RESISTOR_CODE_LO +: RESISTOR_CODE_W]);
         second_kohm_q <= KOHM_W'(KOHM_PER_COUNT)
            * KOHM_W'(second_gain_select[POS_RESISTOR_CODE_LO +: RESISTOR_CODE_W]);
         third_kohm_q <= KOHM_W'(THIRD_KOHM_STEP)
            * (KOHM_W'(second_gain_select[POS_THIRD_CODE_LO +: THIRD_CODE_W]) + KOHM_W'(1));
      end
   end

   // switch one is not interlocked against DC coupling: software owns that
   // choice, and a hidden override would make readback lie
   assign o_SWITCH_ZERO_ON = switch_mode_ctrl[POS_SWITCH_ZERO];
   assign o_SWITCH_ONE_ON = switch_mode_ctrl[POS_SWITCH_ONE];
   assign o_SWITCH_TWO_ON = switch_mode_ctrl[POS_SWITCH_TWO];
   assign o_SWITCH_THREE_ON = switch_mode_ctrl[POS_SWITCH_THREE];
   assign o_SWITCH_FOUR_ON = switch_mode_ctrl[POS_SWITCH_FOUR];
   assign o_COUPLING_EXTERNAL = coupling_ext_q;
   assign o_COUPLING_AC = coupling_ac_q;
   assign o_COUPLING_DC = coupling_dc_q;
   assign o_FIRST_RESISTOR_CODE = first_gain_select[POS_RESISTOR_CODE_LO +: RESISTOR_CODE_W];
   assign o_SECOND_RESISTOR_CODE = second_gain_select[POS_RESISTOR_CODE_LO +: RESISTOR_CODE_W];
   assign o_THIRD_RESISTOR_CODE = second_gain_select[POS_THIRD_CODE_LO +: THIRD_CODE_W];
   assign o_FIRST_RESISTOR_KOHM = first_kohm_q;
   assign o_SECOND_RESISTOR_KOHM = second_kohm_q;
   assign o_THIRD_RESISTOR_KOHM = third_kohm_q;
   assign o_AMP_ZERO_ENABLE = amp_zero_ctrl[POS_AMP_ENABLE];
   assign o_AMP_ZERO_CALIBRATION_MODE = cal_mode;
   assign o_AMP_ZERO_BANDWIDTH_SELECT = amp_zero_ctrl[POS_BANDWIDTH_LO +: BANDWIDTH_W];
   assign o_AMP_ZERO_BANDWIDTH_ONEHOT = bw_onehot_q;

endmodule

// file: hw/afec_pkg.sv
/*
 * Constants for the optical front-end control register bank: register byte
 * offsets, implemented-bit masks, reset values, field positions and the
 * decoded coupling and bandwidth modes.
 * Assumes a 32-bit Avalon-MM data path with 8-bit registers in the low lane.
 */
package afec_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;

   // byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] OFS_SWITCH_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_FIRST_GAIN = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SECOND_GAIN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_AMP_ZERO_CTRL = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_AMP_ZERO_CAL = 8'h10;

   // implemented (writable) bits
   localparam logic [REG_W-1:0] MASK_SWITCH_MODE = 8'h7F;
   localparam logic [REG_W-1:0] MASK_FIRST_GAIN = 8'h3F;
   localparam logic [REG_W-1:0] MASK_SECOND_GAIN = 8'hFF;
   localparam logic [REG_W-1:0] MASK_AMP_ZERO_CTRL = 8'h43;
   localparam logic [REG_W-1:0] MASK_AMP_ZERO_CAL = 8'h80;

   localparam logic [REG_W-1:0] RST_SWITCH_MODE = 8'h00;
   localparam logic [REG_W-1:0] RST_FIRST_GAIN = 8'h00;
   localparam logic [REG_W-1:0] RST_SECOND_GAIN = 8'h00;
   localparam logic [REG_W-1:0] RST_AMP_ZERO_CTRL = 8'h00;
   localparam logic [REG_W-1:0] RST_AMP_ZERO_CAL = 8'h00;

   // field positions
   localparam int POS_SWITCH_ZERO = 0;
   localparam int POS_SWITCH_ONE = 1;
   localparam int POS_SWITCH_TWO = 2;
   localparam int POS_SWITCH_THREE = 3;
   localparam int POS_SWITCH_FOUR = 4;
   localparam int POS_COUPLING_LO = 5;
   localparam int POS_RESISTOR_CODE_LO = 0;
   localparam int RESISTOR_CODE_W = 6;
   localparam int POS_THIRD_CODE_LO = 6;
   localparam int THIRD_CODE_W = 2;
   localparam int POS_AMP_ENABLE = 6;
   localparam int POS_AMP_STATUS = 5;
   localparam int POS_BANDWIDTH_LO = 0;
   localparam int BANDWIDTH_W = 2;
   localparam int POS_CAL_MODE = 7;

   // resistor scaling in kilohm
   localparam int KOHM_PER_COUNT = 100;
   localparam int THIRD_KOHM_STEP = 10;
   localparam int KOHM_W = 13;

   typedef enum logic [1:0] {
      CPL_EXTERNAL_A = 2'b00,
      CPL_AC = 2'b01,
      CPL_EXTERNAL_B = 2'b10,
      CPL_DC = 2'b11
   } afec_coupling_t;

   typedef enum logic [1:0] {
      BW_5KHZ = 2'b00,
      BW_40KHZ = 2'b01,
      BW_600KHZ = 2'b10,
      BW_2MHZ = 2'b11
   } afec_bandwidth_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_ACK = 1'b1
   } afec_bus_state_t;

endpackage

// file: hw/afec_field_reg.sv
/*
 * One software register of the bank: only the bits in the mask hold state,
 * the others are constant zero.
 * Assumes the caller qualifies the write strobe with address and lane.
 */
`timescale 1ns/100ps
module afec_field_reg #(
   parameter int WIDTH = 8,
   parameter logic [WIDTH-1:0] MASK = '1,
   parameter logic [WIDTH-1:0] RST = '0
) (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire logic i_wr_en,
   input wire logic [WIDTH-1:0] i_wr_data,
   output logic [WIDTH-1:0] o_value
);

   logic [WIDTH-1:0] value_q;

   // masked bits never take a 1, so they always read back zero
   always_ff @(posedge i_ref_clk or posedge i_reset) begin
      if (i_reset) begin
         value_q <= RST & MASK;
      end else if (i_wr_en) begin
         value_q <= i_wr_data & MASK;
      end
   end

   assign o_value = value_q;

endmodule

// file: bench/afec_regbank_sva.sv
/* Port checker for the optical front-end register bank.
   Bound to afec_regbank; sees only its ports, one clock domain. */
`timescale 1ns/100ps
module afec_regbank_sva
   import afec_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_RESET,
   input wire logic [ADDR_W-1:0] i_AVS_ADDRESS,
   input wire logic i_AVS_READ,
   input wire logic i_AVS_WRITE,
   input wire logic [DATA_W-1:0] i_AVS_WRITEDATA,
   input wire logic [DATA_W/8-1:0] i_AVS_BYTEENABLE,
   input wire logic [DATA_W-1:0] o_AVS_READDATA,
   input wire logic o_AVS_WAITREQUEST,
   input wire logic i_AMP_ZERO_OUTPUT,
   input wire logic o_SWITCH_ZERO_ON,
   input wire logic o_SWITCH_ONE_ON,
   input wire logic o_SWITCH_TWO_ON,
   input wire logic o_SWITCH_THREE_ON,
   input wire logic o_SWITCH_FOUR_ON,
   input wire logic o_COUPLING_EXTERNAL,
   input wire logic o_COUPLING_AC,
   input wire logic o_COUPLING_DC,
   input wire logic [RESISTOR_CODE_W-1:0] o_FIRST_RESISTOR_CODE,
   input wire logic [RESISTOR_CODE_W-1:0] o_SECOND_RESISTOR_CODE,
   input wire logic [THIRD_CODE_W-1:0] o_THIRD_RESISTOR_CODE,
   input wire logic [KOHM_W-1:0] o_FIRST_RESISTOR_KOHM,
   input wire logic [KOHM_W-1:0] o_SECOND_RESISTOR_KOHM,
   input wire logic [KOHM_W-1:0] o_THIRD_RESISTOR_KOHM,
   input wire logic o_AMP_ZERO_ENABLE,
   input wire logic o_AMP_ZERO_CALIBRATION_MODE,
   input wire logic [BANDWIDTH_W-1:0] o_AMP_ZERO_BANDWIDTH_SELECT,
   input wire logic [3:0] o_AMP_ZERO_BANDWIDTH_ONEHOT
);
   logic [7:0] wd_q;
   logic wr_ok;
   logic rd_take;
   logic [1:0] wcpl;
   // write data of the ack edge, seen one cycle on
   always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
      if (I_RESET) begin
         wd_q <= 8'h00;
      end else begin
         wd_q <= i_AVS_WRITEDATA[7:0];
      end
   end
   assign wcpl = i_AVS_WRITEDATA[6:5];
   assign wr_ok = i_AVS_WRITE && !o_AVS_WAITREQUEST && i_AVS_BYTEENABLE[0];
   assign rd_take = i_AVS_READ && o_AVS_WAITREQUEST && i_AVS_ADDRESS == OFS_AMP_ZERO_CTRL;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_RESET);
   sequence wr_to(logic [7:0] a);
      wr_ok && i_AVS_ADDRESS == a;
   endsequence
   chk_switch_bits: assert property (wr_to(OFS_SWITCH_MODE) |=> {o_SWITCH_FOUR_ON,
      o_SWITCH_THREE_ON, o_SWITCH_TWO_ON, o_SWITCH_ONE_ON, o_SWITCH_ZERO_ON} == wd_q[4:0])
      else $error("switch lines differ from written bits");
   chk_coupling_decode: assert property (wr_to(OFS_SWITCH_MODE) |-> ##2
      (o_COUPLING_DC == ($past(wcpl, 2) == 2'b11) && o_COUPLING_AC == ($past(wcpl, 2) == 2'b01)
      && o_COUPLING_EXTERNAL == ($past(wcpl, 2) inside {2'b00, 2'b10})))
      else $error("coupling decode wrong");
   chk_first_code: assert property (wr_to(OFS_FIRST_GAIN) |=>
      o_FIRST_RESISTOR_CODE == wd_q[5:0]) else $error("first resistor code wrong");
   chk_second_gain: assert property (wr_to(OFS_SECOND_GAIN) |=>
      {o_THIRD_RESISTOR_CODE, o_SECOND_RESISTOR_CODE} == wd_q) else $error("second gain wrong");
   chk_kohm_scale: assert property (1'b1 |=>
      int'(o_FIRST_RESISTOR_KOHM) == KOHM_PER_COUNT * $past(o_FIRST_RESISTOR_CODE)
      && int'(o_SECOND_RESISTOR_KOHM) == KOHM_PER_COUNT * $past(o_SECOND_RESISTOR_CODE)
      && int'(o_THIRD_RESISTOR_KOHM) == THIRD_KOHM_STEP * ($past(o_THIRD_RESISTOR_CODE) + 1))
      else $error("resistor figure wrong");
   chk_amp_ctrl: assert property (wr_to(OFS_AMP_ZERO_CTRL) |=> o_AMP_ZERO_ENABLE == wd_q[6]
      && o_AMP_ZERO_BANDWIDTH_SELECT == wd_q[1:0]) else $error("amplifier control wrong");
   chk_bw_onehot: assert property (1'b1 |=> o_AMP_ZERO_BANDWIDTH_ONEHOT ==
      4'h1 << $past(o_AMP_ZERO_BANDWIDTH_SELECT)) else $error("bandwidth one-hot wrong");
   chk_cal_mode: assert property (wr_to(OFS_AMP_ZERO_CAL) |=>
      o_AMP_ZERO_CALIBRATION_MODE == wd_q[7]) else $error("calibration mode bit wrong");
   chk_status_gate: assert property (rd_take |=> o_AVS_READDATA[POS_AMP_STATUS] ==
      ($past(o_AMP_ZERO_CALIBRATION_MODE, 2) && $past(i_AMP_ZERO_OUTPUT, 2)))
      else $error("output status not gated by calibration mode");
   chk_read_upper: assert property (i_AVS_READ && !o_AVS_WAITREQUEST |->
      o_AVS_READDATA[31:8] == 24'h000000) else $error("upper read data not zero");
endmodule

bind afec_regbank afec_regbank_sva u_afec_regbank_sva (
   .I_REF_CLK, .I_RESET, .i_AVS_ADDRESS, .i_AVS_READ, .i_AVS_WRITE, .i_AVS_WRITEDATA,
   .i_AVS_BYTEENABLE, .o_AVS_READDATA, .o_AVS_WAITREQUEST, .i_AMP_ZERO_OUTPUT,
   .o_SWITCH_ZERO_ON, .o_SWITCH_ONE_ON, .o_SWITCH_TWO_ON, .o_SWITCH_THREE_ON,
   .o_SWITCH_FOUR_ON, .o_COUPLING_EXTERNAL, .o_COUPLING_AC, .o_COUPLING_DC,
   .o_FIRST_RESISTOR_CODE, .o_SECOND_RESISTOR_CODE, .o_THIRD_RESISTOR_CODE,
   .o_FIRST_RESISTOR_KOHM, .o_SECOND_RESISTOR_KOHM, .o_THIRD_RESISTOR_KOHM,
   .o_AMP_ZERO_ENABLE, .o_AMP_ZERO_CALIBRATION_MODE, .o_AMP_ZERO_BANDWIDTH_SELECT,
   .o_AMP_ZERO_BANDWIDTH_ONEHOT
);

// file: bench/afec_regbank_bench.sv
/* Self-checking bench for the optical front-end register bank.
   Drives the Avalon-MM slave and the amplifier status input directly. */
`timescale 1ns/100ps
module afec_regbank_bench
   import afec_pkg::*;
;
   logic I_REF_CLK = 1'b0;
   logic I_RESET = 1'b1;
   logic [ADDR_W-1:0] i_AVS_ADDRESS = '0;
   logic i_AVS_READ = 1'b0, i_AVS_WRITE = 1'b0, i_AMP_ZERO_OUTPUT = 1'b0;
   logic [DATA_W-1:0] i_AVS_WRITEDATA = '0, o_AVS_READDATA;
   logic [DATA_W/8-1:0] i_AVS_BYTEENABLE = '0;
   logic o_AVS_WAITREQUEST, o_SWITCH_ZERO_ON, o_SWITCH_ONE_ON, o_SWITCH_TWO_ON;
   logic o_SWITCH_THREE_ON, o_SWITCH_FOUR_ON, o_COUPLING_EXTERNAL, o_COUPLING_AC;
   logic o_COUPLING_DC, o_AMP_ZERO_ENABLE, o_AMP_ZERO_CALIBRATION_MODE;
   logic [RESISTOR_CODE_W-1:0] o_FIRST_RESISTOR_CODE, o_SECOND_RESISTOR_CODE;
   logic [THIRD_CODE_W-1:0] o_THIRD_RESISTOR_CODE;
   logic [KOHM_W-1:0] o_FIRST_RESISTOR_KOHM, o_SECOND_RESISTOR_KOHM, o_THIRD_RESISTOR_KOHM;
   logic [BANDWIDTH_W-1:0] o_AMP_ZERO_BANDWIDTH_SELECT;
   logic [3:0] o_AMP_ZERO_BANDWIDTH_ONEHOT;
   logic [31:0] rd;
   int fails = 0;
   int compares = 0;

   afec_regbank u_afec_regbank (
      .I_REF_CLK, .I_RESET, .i_AVS_ADDRESS, .i_AVS_READ, .i_AVS_WRITE, .i_AVS_WRITEDATA,
      .i_AVS_BYTEENABLE, .o_AVS_READDATA, .o_AVS_WAITREQUEST, .i_AMP_ZERO_OUTPUT,
      .o_SWITCH_ZERO_ON, .o_SWITCH_ONE_ON, .o_SWITCH_TWO_ON, .o_SWITCH_THREE_ON,
      .o_SWITCH_FOUR_ON, .o_COUPLING_EXTERNAL, .o_COUPLING_AC, .o_COUPLING_DC,
      .o_FIRST_RESISTOR_CODE, .o_SECOND_RESISTOR_CODE, .o_THIRD_RESISTOR_CODE,
      .o_FIRST_RESISTOR_KOHM, .o_SECOND_RESISTOR_KOHM, .o_THIRD_RESISTOR_KOHM,
      .o_AMP_ZERO_ENABLE, .o_AMP_ZERO_CALIBRATION_MODE, .o_AMP_ZERO_BANDWIDTH_SELECT,
      .o_AMP_ZERO_BANDWIDTH_ONEHOT
   );

   always #5 I_REF_CLK = ~I_REF_CLK;

   task automatic close_out();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one transfer; holds everything until waitrequest is sampled low
   task automatic bus(bit wr, logic [7:0] a, logic [31:0] d, logic [3:0] be);
      int n;
      n = 0;
      @(posedge I_REF_CLK);
      i_AVS_ADDRESS <= a;
      i_AVS_WRITEDATA <= d;
      i_AVS_BYTEENABLE <= be;
      i_AVS_WRITE <= wr;
      i_AVS_READ <= !wr;
      do begin
         @(posedge I_REF_CLK);
         n++;
      end while (o_AVS_WAITREQUEST !== 1'b0 && n < 20);
      if (o_AVS_WAITREQUEST !== 1'b0) begin
         fails++;
         close_out();
      end
      rd = o_AVS_READDATA;
      i_AVS_WRITE <= 1'b0;
      i_AVS_READ <= 1'b0;
   endtask

   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(1'b1, a, {24'h000000, d}, 4'hF);
   endtask

   task automatic rdc(logic [7:0] a, logic [7:0] exp, string nm);
      bus(1'b0, a, 32'h00000000, 4'hF);
      check(nm, rd, {24'h000000, exp});
   endtask

   // decoded outputs lag the register by one more cycle
   task automatic settle();
      repeat (2) @(posedge I_REF_CLK);
   endtask

   task automatic t_reset();
      logic [7:0] ofs [5];
      ofs = '{OFS_SWITCH_MODE, OFS_FIRST_GAIN, OFS_SECOND_GAIN, OFS_AMP_ZERO_CTRL, OFS_AMP_ZERO_CAL};
      for (int i = 0; i < 5; i++) begin
         rdc(ofs[i], 8'h00, "reset value");
      end
      check("reset coupling", {o_COUPLING_EXTERNAL, o_COUPLING_DC}, 2'b10);
      check("reset third kohm", o_THIRD_RESISTOR_KOHM, 13'd10);
   endtask

   task automatic t_switch();
      logic [7:0] d;
      for (int c = 0; c < 4; c++) begin
         d = {1'b1, c[1:0], 5'h1F ^ 5'(c * 11)};
         if (c == 3) begin
            d[1] = 1'b0;
         end
         wr(OFS_SWITCH_MODE, d);
         settle();
         check("switches", {o_SWITCH_FOUR_ON, o_SWITCH_THREE_ON,
            o_SWITCH_TWO_ON, o_SWITCH_ONE_ON, o_SWITCH_ZERO_ON}, d[4:0]);
         check("coupling", {o_COUPLING_EXTERNAL, o_COUPLING_AC, o_COUPLING_DC},
            {c[0] == 1'b0, c == 1, c == 3});
         rdc(OFS_SWITCH_MODE, d & 8'h7F, "switch reg");
      end
   endtask

   task automatic t_gains();
      logic [7:0] d;
      logic [5:0] f;
      for (int k = 0; k < 4; k++) begin
         d = {k[1:0], 6'(k * 21)};
         f = 6'(63 - k * 21);
         wr(OFS_SECOND_GAIN, d);
         wr(OFS_FIRST_GAIN, {2'b11, f});
         settle();
         check("first code", o_FIRST_RESISTOR_CODE, f);
         check("first kohm", o_FIRST_RESISTOR_KOHM, 100 * f);
         check("second kohm", o_SECOND_RESISTOR_KOHM, 100 * d[5:0]);
         check("third kohm", o_THIRD_RESISTOR_KOHM, 10 * (k + 1));
         check("codes", {o_THIRD_RESISTOR_CODE, o_SECOND_RESISTOR_CODE}, d);
         rdc(OFS_FIRST_GAIN, {2'b00, f}, "first gain reg");
         rdc(OFS_SECOND_GAIN, d, "second gain reg");
      end
   endtask

   // status input held high: must still read 0 outside calibration
   task automatic t_amp();
      i_AMP_ZERO_OUTPUT <= 1'b1;
      for (int b = 0; b < 4; b++) begin
         wr(OFS_AMP_ZERO_CTRL, {1'b1, b[0], 4'hF, b[1:0]});
         settle();
         check("enable", o_AMP_ZERO_ENABLE, b[0]);
         check("onehot", o_AMP_ZERO_BANDWIDTH_ONEHOT, 4'h1 << b);
         check("bw select", o_AMP_ZERO_BANDWIDTH_SELECT, b[1:0]);
         rdc(OFS_AMP_ZERO_CTRL, {1'b0, b[0], 4'h0, b[1:0]}, "amp ctrl");
      end
   endtask

   task automatic t_status();
      wr(OFS_AMP_ZERO_CAL, 8'hFF);
      settle();
      check("cal mode on", o_AMP_ZERO_CALIBRATION_MODE, 1'b1);
      rdc(OFS_AMP_ZERO_CAL, 8'h80, "cal reg");
      rdc(OFS_AMP_ZERO_CTRL, 8'h63, "status high");
      i_AMP_ZERO_OUTPUT <= 1'b0;
      rdc(OFS_AMP_ZERO_CTRL, 8'h43, "status low");
      wr(OFS_AMP_ZERO_CAL, 8'h00);
      i_AMP_ZERO_OUTPUT <= 1'b1;
      rdc(OFS_AMP_ZERO_CTRL, 8'h43, "status gated");
      check("cal mode off", o_AMP_ZERO_CALIBRATION_MODE, 1'b0);
   endtask

   // unmapped, misaligned and lane-disabled writes; then reset mid-run
   task automatic t_refused();
      wr(8'h14, 8'hFF);
      wr(8'h01, 8'hFF);
      bus(1'b1, OFS_FIRST_GAIN, 32'h00000015, 4'hE);
      rdc(8'h14, 8'h00, "unmapped");
      rdc(8'h01, 8'h00, "misaligned");
      rdc(OFS_FIRST_GAIN, 8'h00, "lane off");
      @(posedge I_REF_CLK);
      I_RESET <= 1'b1;
      repeat (2) @(posedge I_REF_CLK);
      I_RESET <= 1'b0;
      rdc(OFS_SECOND_GAIN, 8'h00, "second reset");
      rdc(OFS_AMP_ZERO_CTRL, 8'h00, "ctrl after reset");
   endtask

   initial begin
      repeat (4) @(posedge I_REF_CLK);
      I_RESET <= 1'b0;
      t_reset();
      t_switch();
      t_gains();
      t_amp();
      t_status();
      t_refused();
      close_out();
   end
endmodule
